// File: src/lpm_device.sv
// Standby and clock switch sequencer, device end
//
// The register addresses and the strobed register port were decided locally.
`default_nettype none
// Overview of operation
// R1: Halt gates all peripheral clocks except time base
// R2: Halt keeps memory, registers, latches unchanged
// R3: Held program counter is entry address plus two
// R4: Software stops timers before entering halt
// R5: Writing halt bit one starts timer halt
// R6: Release clears halt bit, resumes previous mode
// R7: Master, enable, time base AND picks release
// R8: Time base enabled at entry sets its latch
// R9: Halt works whatever time base enable is
// R10: Normal release on selected source falling edge
// R11: Interrupt release starts time base interrupt
// R12: Asynchronous release may shorten the halt
// R13: Pending watchdog interrupt blocks halt entry
// R14: Reset releases halt into single clock normal
// R15: Select low clock first, then stop high
// R16: High oscillator off before any stop mode
// R17: High on, warm up, then clear select
// R18: Low clock runs until clocks are synchronized
// R19: Reset releases low speed into normal mode
// R20: Timer pair mode 05H counts warm-up, interrupts
// R21: Warm-up counter cleared on resume from halt
// R22: Release edge synchronized before clearing halt
// R23: Clock select changes only at clean handover
module lpm_device
	import lpm_pkg::*;
#(
	parameter int TB_SRC_N = 8 // Time base source taps
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// CPU side link
	lpm_if.dev link,
	// Clock sources as pins
	input wire logic [TB_SRC_N-1:0] tb_src_in,
	input wire logic low_clk_in,
	// Clock and oscillator controls, held program counter
	output logic periph_clk_en_out,
	output logic tbt_clk_en_out,
	output logic core_hold_out,
	output logic high_osc_en_out,
	output logic low_osc_en_out,
	output logic clk_sel_low_out,
	output logic [15:0] held_pc_out
);
	localparam int SN = TB_SRC_N + 1; // Sources plus low clock

	// ********************************************************
	// Parameter check
	// ********************************************************
	if (TB_SRC_N != (1 << TBC_SEL_W)) begin : g_bad_taps
		$error("TB_SRC_N must match the clock select field");
	end

	// ********************************************************
	// Registers and state
	// ********************************************************
	logic [7:0] sc2; // system_control_two
	logic [7:0] tbc; // time_base_control
	logic [7:0] utc; // upper_timer_control
	logic [7:0] ltc; // lower_timer_control
	logic [7:0] wlo; // Warm-up limit low
	logic [7:0] whi; // Warm-up limit high
	logic [15:0] warm_cnt; // Warm-up counter
	logic rel_irq; // Release kind caught at entry
	logic sel_low; // Clock actually in use, 1 = low
	lpm_dev_state_type state, next_state;
	logic [SN-1:0] raw, s1, s2, s3, lvl, fall;
	logic sel_fall, lo_rise, wr_sc2, halt_req, enter, refuse;
	logic warm_run;

	// ********************************************************
	// Pin synchronisers and edge detection
	// ********************************************************
	assign raw = {low_clk_in, tb_src_in};
	for (genvar i = 0; i < SN; i++) begin : g_sync
		// Three stages; a level counts once stages two and three agree
		always_ff @(posedge sys_clk_in or posedge reset_in) begin
			if (reset_in) begin
				s1[i] <= 1'b0;
				s2[i] <= 1'b0;
				s3[i] <= 1'b0;
				lvl[i] <= 1'b0;
			end else begin
				s1[i] <= raw[i];
				s2[i] <= s1[i];
				s3[i] <= s2[i];
				if (s2[i] == s3[i]) begin
					lvl[i] <= s3[i];
				end
			end
		end
		// Settled falling edge of this input
		assign fall[i] = lvl[i] & ~s2[i] & ~s3[i];
	end
	// Selected time base source edge; the source runs free of sys_clk,
	// so the halt can end early within one source period [R12]
	assign sel_fall = fall[tbc[TBC_SEL_W-1:0]]; // [R22]
	// Rising edge of the low clock marks the handover point
	assign lo_rise = ~lvl[SN-1] & s2[SN-1] & s3[SN-1];

	// ********************************************************
	// Entry decode
	// ********************************************************
	assign wr_sc2 = link.wr && (link.addr == SC2_ADDR);
	assign halt_req = wr_sc2 && link.wdata[SC2_HALT]; // [R5]
	// Entry never looks at the time base enable [R9]
	assign enter = halt_req && !link.wdt_irq && (state == DS_RUN);
	assign refuse = halt_req && link.wdt_irq; // [R13]

	// ********************************************************
	// Halt state machine
	// ********************************************************
	always_comb begin
		next_state = state;
		case (state)
			DS_RUN: begin
				if (enter) begin
					next_state = DS_HALT;
				end
			end
			DS_HALT: begin
				// Leave only on the settled source edge [R10] [R11]
				if (sel_fall) begin
					next_state = DS_WAKE;
				end
			end
			DS_WAKE: begin
				next_state = DS_RUN;
			end
			default: begin
				next_state = DS_RUN;
			end
		endcase
	end

	// State register; reset always lands in running state [R14]
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= DS_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Release kind caught at entry [R7]
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rel_irq <= 1'b0;
		end else if (enter) begin
			rel_irq <= link.interrupt_master_flag & link.tb_irq_en & tbc[TBC_EN];
		end
	end

	// Link pulses: latch set, wake and release kind
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			link.tb_latch_set <= 1'b0;
			link.wake <= 1'b0;
			link.wake_irq <= 1'b0;
		end else begin
			link.tb_latch_set <= enter && tbc[TBC_EN]; // [R8]
			// Wake on release, or at once when entry is refused [R13]
			link.wake <= (next_state == DS_WAKE) || refuse;
			// Interrupt release asks for time base service [R11]
			link.wake_irq <= (next_state == DS_WAKE) && rel_irq;
		end
	end

	// Held program counter, captured at entry [R3]
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			held_pc_out <= 16'h0000;
		end else if (enter) begin
			held_pc_out <= link.entry_pc + 16'h0002;
		end
	end

	// ********************************************************
	// Register writes
	// ********************************************************
	// system_control_two; reset gives single clock normal [R14] [R19]
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			sc2 <= SC2_RST;
		end else if (wr_sc2) begin
			sc2 <= link.wdata;
			sc2[SC2_HALT] <= link.wdata[SC2_HALT] && !link.wdt_irq;
		end else if (next_state == DS_WAKE) begin
			sc2[SC2_HALT] <= 1'b0; // [R6]
		end
	end

	// Other control registers; nothing changes while halted [R2]
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			tbc <= REG_RST;
			utc <= REG_RST;
			ltc <= REG_RST;
			wlo <= REG_RST;
			whi <= REG_RST;
		end else if (link.wr && state == DS_RUN) begin
			case (link.addr)
				TBC_ADDR: tbc <= link.wdata;
				UTC_ADDR: utc <= link.wdata;
				LTC_ADDR: ltc <= link.wdata;
				WLO_ADDR: wlo <= link.wdata;
				WHI_ADDR: whi <= link.wdata;
				default: begin
				end
			endcase
		end
	end

	// Read port, data in the cycle after the strobe
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			link.rdata <= 8'h00;
		end else if (link.rd) begin
			case (link.addr)
				SC2_ADDR: link.rdata <= sc2;
				TBC_ADDR: link.rdata <= tbc;
				UTC_ADDR: link.rdata <= utc;
				LTC_ADDR: link.rdata <= ltc;
				WLO_ADDR: link.rdata <= wlo;
				WHI_ADDR: link.rdata <= whi;
				STAT_ADDR: link.rdata <= {5'h00, sel_low, state};
				default: link.rdata <= 8'h00;
			endcase
		end else begin
			link.rdata <= 8'h00;
		end
	end

	// ********************************************************
	// Warm-up counter
	// ********************************************************
	assign warm_run = ((utc & UTC_MODE_MASK) == WARMUP_MODE)
		&& utc[UTC_START]; // [R20]

	// Counts to the limit, then raises the interrupt and reloads
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			warm_cnt <= 16'h0000;
			link.warmup_irq <= 1'b0;
		end else begin
			link.warmup_irq <= 1'b0;
			if (state != DS_RUN || !warm_run) begin
				warm_cnt <= 16'h0000; // [R21]
			end else if (warm_cnt == {whi, wlo}) begin
				warm_cnt <= 16'h0000;
				link.warmup_irq <= 1'b1; // [R20]
			end else begin
				warm_cnt <= warm_cnt + 16'h0001;
			end
		end
	end

	// ********************************************************
	// Clock handover
	// ********************************************************
	// Switch only on a low clock edge with the target running,
	// so no shortened pulse appears [R18] [R23]
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			sel_low <= 1'b0; // [R19]
		end else if (sel_low != sc2[SC2_SYSCK] && lo_rise
			&& (sc2[SC2_SYSCK] ? sc2[SC2_XTEN] : sc2[SC2_XEN])) begin
			sel_low <= sc2[SC2_SYSCK];
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			periph_clk_en_out <= 1'b1;
			tbt_clk_en_out <= 1'b0;
			core_hold_out <= 1'b0;
			link.cpu_hold <= 1'b0;
			high_osc_en_out <= 1'b1;
			low_osc_en_out <= 1'b0;
			clk_sel_low_out <= 1'b0;
		end else begin
			periph_clk_en_out <= (next_state != DS_HALT); // [R1]
			tbt_clk_en_out <= tbc[TBC_EN];
			core_hold_out <= (next_state == DS_HALT); // [R2]
			link.cpu_hold <= (next_state == DS_HALT);
			high_osc_en_out <= sc2[SC2_XEN];
			low_osc_en_out <= sc2[SC2_XTEN];
			clk_sel_low_out <= sel_low;
		end
	end
endmodule
`default_nettype wire

// File: src/lpm_pkg.sv
// Shared constants and types for the low power mode controller
`default_nettype none
package lpm_pkg;
	// ********************************************************
	// Register map of the controller (device end)
	// ********************************************************
	localparam int ADDR_W = 3; // Register address width
	localparam int DATA_W = 8; // Register data width
	localparam logic [2:0] SC2_ADDR = 3'h0; // system_control_two
	localparam logic [2:0] TBC_ADDR = 3'h1; // time_base_control
	localparam logic [2:0] UTC_ADDR = 3'h2; // upper_timer_control
	localparam logic [2:0] LTC_ADDR = 3'h3; // lower_timer_control
	localparam logic [2:0] WLO_ADDR = 3'h4; // Warm-up limit, low byte
	localparam logic [2:0] WHI_ADDR = 3'h5; // Warm-up limit, high byte
	localparam logic [2:0] STAT_ADDR = 3'h6; // Mode and clock status
	// Field positions
	localparam int SC2_XEN = 7; // High oscillator enable
	localparam int SC2_XTEN = 6; // Low oscillator enable
	localparam int SC2_SYSCK = 5; // Clock select, 1 = low clock
	localparam int SC2_HALT = 2; // timing_gen_halt_bit
	localparam int TBC_EN = 3; // time_base_enable_bit
	localparam int TBC_SEL_W = 3; // time_base_clock_select width
	localparam int UTC_START = 3; // Timer pair start bit
	// Reset values: single_clock_normal_mode
	localparam logic [7:0] SC2_RST = 8'h80;
	localparam logic [7:0] REG_RST = 8'h00;
	// Warm-up counter mode of the timer pair
	localparam logic [7:0] WARMUP_MODE = 8'h05;
	localparam logic [7:0] UTC_MODE_MASK = 8'hF7;
	localparam logic [7:0] UTC_RUN = 8'h0D; // Mode plus start bit
	// ********************************************************
	// Host command port map
	// ********************************************************
	localparam logic [2:0] H_CMD = 3'h0; // Command, write only
	localparam logic [2:0] H_STAT = 3'h1; // Status, write 1 to clear
	localparam logic [2:0] H_WLO = 3'h2; // Warm-up limit low
	localparam logic [2:0] H_WHI = 3'h3; // Warm-up limit high
	localparam logic [2:0] H_TBC = 3'h4; // Time base setting
	localparam logic [2:0] H_DEV = 3'h5; // Mirrored device status
	localparam logic [2:0] CMD_HALT = 3'h1; // Enter timer-halt mode
	localparam logic [2:0] CMD_SLOW = 3'h2; // Go to low-speed mode
	localparam logic [2:0] CMD_NORMAL = 3'h3; // Back to dual clock
	localparam logic [2:0] CMD_TBASE = 3'h4; // Load time base setting
	// Wait kinds of a host step
	localparam logic [1:0] W_NONE = 2'h0;
	localparam logic [1:0] W_WARM = 2'h1;
	localparam logic [1:0] W_WAKE = 2'h2;
	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [1:0] {
		DS_RUN = 2'b00,
		DS_HALT = 2'b01,
		DS_WAKE = 2'b11
	} lpm_dev_state_type;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_WRITE = 2'b01,
		HS_WAIT = 2'b11
	} lpm_host_state_type;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] data;
		logic [1:0] wait_kind;
		logic last;
	} lpm_op_type;
endpackage
`default_nettype wire

// File: src/lpm_if.sv
// Link between the controller and the CPU side
`default_nettype none
interface lpm_if;
	logic [2:0] addr; // Register address
	logic [7:0] wdata; // Register write data
	logic wr; // Write strobe
	logic rd; // Read strobe
	logic [7:0] rdata; // Read data, cycle after rd
	logic interrupt_master_flag; // interrupt_master_flag
	logic tb_irq_en; // time_base_irq_enable
	logic wdt_irq; // Watchdog interrupt pending
	logic [15:0] entry_pc; // Address of the entry instruction
	logic cpu_hold; // Core halted
	logic tb_latch_set; // Pulse: set time base latch
	logic wake; // Pulse: halt ended or refused
	logic wake_irq; // With wake: interrupt release
	logic warmup_irq; // Pulse: warmup_timer_interrupt
	modport dev (
		input addr, wdata, wr, rd, interrupt_master_flag, tb_irq_en, wdt_irq, entry_pc,
		output rdata, cpu_hold, tb_latch_set, wake, wake_irq, warmup_irq
	);
	modport cpu (
		output addr, wdata, wr, rd, interrupt_master_flag, tb_irq_en, wdt_irq, entry_pc,
		input rdata, cpu_hold, tb_latch_set, wake, wake_irq, warmup_irq
	);
endinterface
`default_nettype wire

// File: src/lpm_host.sv
// CPU side sequencer driving the controller link
`default_nettype none
module lpm_host
	import lpm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Controller link
	lpm_if.cpu link,
	// Software command port
	input wire logic [2:0] usr_addr_in,
	input wire logic [7:0] usr_wdata_in,
	input wire logic usr_wr_in,
	input wire logic usr_rd_in,
	output logic [7:0] usr_rdata_out,
	// Core state
	input wire logic imf_in,
	input wire logic tb_irq_en_in,
	input wire logic wdt_irq_in,
	input wire logic [15:0] pc_in,
	// Status
	output logic busy_out,
	output logic tb_latch_out,
	output logic warm_latch_out
);
	// ********************************************************
	// Step table
	// ********************************************************
	function automatic lpm_op_type step_op(input logic [2:0] cmd,
		input logic [2:0] step, input logic [7:0] sh,
		input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] tb);
		lpm_op_type op;
		op = '{addr: SC2_ADDR, data: sh, wait_kind: W_NONE, last: 1'b1};
		case (cmd)
			CMD_HALT: begin
				// Stop the timer pair first [R4]
				if (step == 3'h0) begin
					op = '{UTC_ADDR, REG_RST, W_NONE, 1'b0};
				end else begin
					op.data[SC2_HALT] = 1'b1; // [R5]
					op.wait_kind = W_WAKE;
				end
			end
			CMD_SLOW: begin
				// Select low clock, then stop high oscillator [R15]
				if (step == 3'h0) begin
					op.data[SC2_SYSCK] = 1'b1;
					op.data[SC2_XTEN] = 1'b1;
					op.last = 1'b0;
				end else begin
					op.data[SC2_XEN] = 1'b0;
				end
			end
			CMD_NORMAL: begin
				// High on, warm up, then clear select [R17] [R20]
				op.last = 1'b0;
				case (step)
					3'h0: op.data[SC2_XEN] = 1'b1;
					3'h1: op = '{WLO_ADDR, lo, W_NONE, 1'b0};
					3'h2: op = '{WHI_ADDR, hi, W_NONE, 1'b0};
					3'h3: op = '{UTC_ADDR, WARMUP_MODE, W_NONE, 1'b0};
					3'h4: op = '{UTC_ADDR, UTC_RUN, W_WARM, 1'b0};
					3'h5: op = '{UTC_ADDR, REG_RST, W_NONE, 1'b0};
					default: begin
						op.data[SC2_SYSCK] = 1'b0;
						op.last = 1'b1;
					end
				endcase
			end
			default: op = '{TBC_ADDR, tb, W_NONE, 1'b1};
		endcase
		// No stop command exists, so a running high oscillator is safe [R16]
		return op;
	endfunction

	// ********************************************************
	// State
	// ********************************************************
	lpm_host_state_type hstate;
	logic [2:0] cmd_q; // Command in progress
	logic [2:0] step; // Step within command
	logic [7:0] shadow; // Last value written to system_control_two, halt bit cleared
	logic [7:0] wlo, whi, tbv; // Software settings
	logic [7:0] dev_stat; // Mirrored controller status
	logic rd_q; // Status read in flight
	logic wake_irq_q; // Last release was interrupt release
	lpm_op_type op;
	logic cmd_ok, wait_done;

	assign op = step_op(cmd_q, step, shadow, wlo, whi, tbv);
	assign cmd_ok = usr_wr_in && usr_addr_in == H_CMD
		&& usr_wdata_in[2:0] >= CMD_HALT && usr_wdata_in[2:0] <= CMD_TBASE;
	assign wait_done = (op.wait_kind == W_WARM) ? link.warmup_irq
		: link.wake;

	// ********************************************************
	// Sequencer
	// ********************************************************
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			hstate <= HS_IDLE;
			cmd_q <= 3'h0;
			step <= 3'h0;
			shadow <= SC2_RST;
			link.wr <= 1'b0;
			link.rd <= 1'b0;
			link.addr <= 3'h0;
			link.wdata <= 8'h00;
		end else begin
			link.wr <= 1'b0;
			link.rd <= 1'b0;
			case (hstate)
				HS_IDLE: begin
					// Poll controller status while idle
					link.rd <= 1'b1;
					link.addr <= STAT_ADDR;
					if (cmd_ok) begin
						cmd_q <= usr_wdata_in[2:0];
						step <= 3'h0;
						hstate <= HS_WRITE;
					end
				end
				HS_WRITE: begin
					link.wr <= 1'b1;
					link.addr <= op.addr;
					link.wdata <= op.data;
					if (op.addr == SC2_ADDR) begin
						shadow <= op.data & ~(8'h01 << SC2_HALT); // [R6]
					end
					if (op.wait_kind != W_NONE) begin
						hstate <= HS_WAIT;
					end else if (op.last) begin
						hstate <= HS_IDLE;
					end else begin
						step <= step + 3'h1;
					end
				end
				HS_WAIT: begin
					if (wait_done) begin
						hstate <= op.last ? HS_IDLE : HS_WRITE;
						step <= step + 3'h1;
					end
				end
				default: hstate <= HS_IDLE;
			endcase
		end
	end

	// Core state forwarded on the link
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			link.interrupt_master_flag <= 1'b0;
			link.tb_irq_en <= 1'b0;
			link.wdt_irq <= 1'b0;
			link.entry_pc <= 16'h0000;
		end else begin
			link.interrupt_master_flag <= imf_in;
			link.tb_irq_en <= tb_irq_en_in;
			link.wdt_irq <= wdt_irq_in;
			link.entry_pc <= pc_in;
		end
	end

	// ********************************************************
	// Software registers and latches
	// ********************************************************
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wlo <= 8'h00;
			whi <= 8'h00;
			tbv <= 8'h00;
		end else if (usr_wr_in) begin
			case (usr_addr_in)
				H_WLO: wlo <= usr_wdata_in;
				H_WHI: whi <= usr_wdata_in;
				H_TBC: tbv <= usr_wdata_in;
				default: begin
				end
			endcase
		end
	end

	// Interrupt latches; a set in the clear cycle wins
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			tb_latch_out <= 1'b0;
			warm_latch_out <= 1'b0;
			wake_irq_q <= 1'b0;
		end else begin
			if (link.tb_latch_set) begin
				tb_latch_out <= 1'b1;
			end else if (usr_wr_in && usr_addr_in == H_STAT
				&& usr_wdata_in[0]) begin
				tb_latch_out <= 1'b0;
			end
			if (link.warmup_irq) begin
				warm_latch_out <= 1'b1;
			end else if (usr_wr_in && usr_addr_in == H_STAT
				&& usr_wdata_in[1]) begin
				warm_latch_out <= 1'b0;
			end
			if (link.wake) begin
				wake_irq_q <= link.wake_irq;
			end
		end
	end

	// Status mirror and read port
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_q <= 1'b0;
			dev_stat <= 8'h00;
			busy_out <= 1'b0;
			usr_rdata_out <= 8'h00;
		end else begin
			rd_q <= link.rd;
			if (rd_q) begin
				dev_stat <= link.rdata;
			end
			busy_out <= (hstate != HS_IDLE) || cmd_ok;
			usr_rdata_out <= 8'h00;
			if (usr_rd_in) begin
				case (usr_addr_in)
					H_STAT: usr_rdata_out <= {4'h0, busy_out, wake_irq_q,
						warm_latch_out, tb_latch_out};
					H_WLO: usr_rdata_out <= wlo;
					H_WHI: usr_rdata_out <= whi;
					H_TBC: usr_rdata_out <= tbv;
					H_DEV: usr_rdata_out <= dev_stat;
					default: usr_rdata_out <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: bench/lpm_link_assertions.sv
// Link checker for the low power mode controller
`default_nettype none
module lpm_link_assertions
	import lpm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Link signals
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic wdt_irq,
	input wire logic cpu_hold,
	input wire logic tb_latch_set,
	input wire logic wake,
	input wire logic wake_irq,
	input wire logic warmup_irq
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	halt_entry_a: assert property (
		wr && addr == SC2_ADDR && wdata[SC2_HALT] && !wdt_irq && !cpu_hold
		|=> cpu_hold) else $error("halt not entered");
	wdt_refuse_a: assert property (
		wr && addr == SC2_ADDR && wdata[SC2_HALT] && wdt_irq && !cpu_hold
		|=> wake && !wake_irq && !cpu_hold) else $error("halt not refused");
	release_wake_a: assert property (
		$fell(cpu_hold) |-> wake) else $error("release without wake");
	wake_pulse_a: assert property (
		wake |=> !wake) else $error("wake longer than a cycle");
	wake_kind_a: assert property (
		wake_irq |-> wake) else $error("stray interrupt release");
	latch_entry_a: assert property (
		tb_latch_set |-> $rose(cpu_hold)) else $error("latch set off entry");
	warm_halt_a: assert property (
		warmup_irq |-> !cpu_hold) else $error("warm-up counted in halt");
	rdata_idle_a: assert property (
		!$past(rd) |-> rdata == 8'h00) else $error("read data not idle");
endmodule
`default_nettype wire

// File: bench/lpm_tb.sv
// Bench for the low power mode controller
`default_nettype none
module lpm_tb
	import lpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus, starting values given at time zero
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [2:0] ua = 3'h0;
	logic [7:0] ud = 8'h00;
	logic uw = 1'b0;
	logic ur = 1'b0;
	logic interrupt_master_flag = 1'b0;
	logic tien = 1'b0;
	logic wdt = 1'b0;
	logic [15:0] pc = 16'h0000;
	logic [7:0] src = 8'h00;
	logic lowck = 1'b0;
	// Observed outputs
	logic pce, tce, hold, hoe, loe, sel, busy, tbl, wml;
	logic [15:0] hpc;
	logic [7:0] rdat;
	int n_fail = 0;
	int check_count = 0;
	int cyc;
	always #20 sys_clk_in = ~sys_clk_in;
	// Low oscillator runs free, unrelated to the system clock
	always #310 lowck = ~lowck;
	lpm_if lpm_if_i ();
	lpm_device lpm_device_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.link(lpm_if_i), .tb_src_in(src), .low_clk_in(lowck),
		.periph_clk_en_out(pce), .tbt_clk_en_out(tce), .core_hold_out(hold),
		.high_osc_en_out(hoe), .low_osc_en_out(loe), .clk_sel_low_out(sel),
		.held_pc_out(hpc));
	lpm_host lpm_host_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.link(lpm_if_i), .usr_addr_in(ua), .usr_wdata_in(ud),
		.usr_wr_in(uw), .usr_rd_in(ur), .usr_rdata_out(rdat),
		.imf_in(interrupt_master_flag), .tb_irq_en_in(tien), .wdt_irq_in(wdt), .pc_in(pc),
		.busy_out(busy), .tb_latch_out(tbl), .warm_latch_out(wml));
	lpm_link_assertions lpm_link_assertions_i (.sys_clk_in(sys_clk_in),
		.reset_in(reset_in), .addr(lpm_if_i.addr), .wdata(lpm_if_i.wdata),
		.wr(lpm_if_i.wr), .rd(lpm_if_i.rd), .rdata(lpm_if_i.rdata),
		.wdt_irq(lpm_if_i.wdt_irq), .cpu_hold(lpm_if_i.cpu_hold),
		.tb_latch_set(lpm_if_i.tb_latch_set), .wake(lpm_if_i.wake),
		.wake_irq(lpm_if_i.wake_irq), .warmup_irq(lpm_if_i.warmup_irq));
	task summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task check(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe on the software port
	task uwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		ua <= a;
		ud <= d;
		uw <= 1'b1;
		@(posedge sys_clk_in);
		uw <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe;
	// they are taken at the edge that closes that cycle
	task urd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge sys_clk_in);
		ua <= a;
		ur <= 1'b1;
		@(posedge sys_clk_in);
		ur <= 1'b0;
		@(posedge sys_clk_in);
		check(rdat, exp);
	endtask
	// Bounded wait: 0 busy, 1 hold, 2 low clock select, 3 warm latch
	task wait_on(input int s, input logic v);
		logic f;
		cyc = 0;
		do begin
			// Values seen at the edge settled in the cycle before it
			@(posedge sys_clk_in);
			cyc++;
			f = s == 0 ? busy : s == 1 ? hold : s == 2 ? sel : wml;
		end while (f !== v && cyc < 3000);
		if (f !== v) begin
			n_fail++;
			summarize();
		end
	endtask
	task cmd(input logic [2:0] c);
		uwr(H_CMD, {5'h00, c});
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		check({pce, tce, hold, hoe, loe, sel}, 6'b100100);
		urd(H_STAT, 8'h00);
		$display("test reset done");
		interrupt_master_flag <= 1'b1;
		tien <= 1'b1;
		pc <= 16'h1234;
		src <= 8'h01;
		uwr(H_TBC, 8'h08);
		cmd(CMD_TBASE);
		wait_on(0, 0);
		cmd(CMD_HALT);
		wait_on(1, 1);
		check({pce, tce, hpc}, {2'b01, 16'h1236});
		src <= 8'h00;
		wait_on(0, 0);
		check({pce, hold, tbl}, 3'b101);
		urd(H_STAT, 8'h05);
		uwr(H_STAT, 8'h03);
		urd(H_STAT, 8'h04);
		$display("test interrupt release done");
		src <= 8'h09;
		uwr(H_TBC, 8'h03);
		cmd(CMD_TBASE);
		wait_on(0, 0);
		cmd(CMD_HALT);
		wait_on(1, 1);
		src <= 8'h08;
		repeat (8) @(posedge sys_clk_in);
		check({tce, hold}, 2'b01);
		src <= 8'h00;
		wait_on(0, 0);
		check(hold, 1'b0);
		urd(H_STAT, 8'h00);
		$display("test normal release done");
		wdt <= 1'b1;
		cmd(CMD_HALT);
		wait_on(0, 0);
		check({hold, pce}, 2'b01);
		wdt <= 1'b0;
		$display("test refusal done");
		cmd(CMD_SLOW);
		wait_on(0, 0);
		wait_on(2, 1);
		check({hoe, loe}, 2'b01);
		urd(H_DEV, 8'h04);
		uwr(H_WLO, 8'h20);
		uwr(H_WHI, 8'h00);
		cmd(CMD_NORMAL);
		wait_on(3, 1);
		check({sel, hoe, cyc >= 33}, 3'b111);
		wait_on(2, 0);
		urd(H_STAT, 8'h02);
		$display("test clock switch done");
		// Halt from low-speed mode, then reset must clear both
		cmd(CMD_SLOW);
		wait_on(0, 0);
		wait_on(2, 1);
		cmd(CMD_HALT);
		wait_on(1, 1);
		reset_in <= 1'b1;
		@(posedge sys_clk_in);
		reset_in <= 1'b0;
		@(posedge sys_clk_in);
		check({pce, hold, sel, hoe}, 4'b1001);
		$display("test reset release done");
		summarize();
	end
endmodule
`default_nettype wire
